// ---- logic/pmic_defines.svh ----
// timing counts, register offsets and field positions shared by both ends
// assumes a 125 MHz clock; included by bare name
`ifndef PMIC_DEFINES_SVH
`define PMIC_DEFINES_SVH

`define CLK_PERIOD_NS 8
`define RANK_GAP_NS 3000000
`define LONG_PRESS_S 16
`define WDG_TICK_NS 1000000

// register offsets on the configuration write path
`define REG_CTRL 8'h00
`define REG_BUCK_MASK 8'h01
`define REG_LDO_MASK 8'h02
`define REG_ALT_BUCK 8'h03
`define REG_ALT_LDO 8'h04
`define REG_WDG_LOAD 8'h05

// control register fields
`define CTRL_SOFTWARE_SWITCH_OFF 0
`define CTRL_RESTART 1
`define CTRL_OCP_EN 2
`define CTRL_WDG_EN 3
`define CTRL_AUTO_ON 4
`define CTRL_RESET 8'h10

// regulator ranks; bit 2 of the buck vector is the main I/O buck
`define BUCK_RANK1 4'h4
`define BUCK_RANK2 4'h8
`define BUCK_RANK3 4'h1
`define LDO_RANK2 6'h10
`define LDO_RANK3 6'h08
`define MAIN_IO_BUCK_BIT 2
`define LAST_RANK 2'h3
`define WDG_LOAD_RESET 16'h1000

`endif

// ---- logic/pmic_pkg.sv ----
// types shared by the device end and the processor end
// no assumptions beyond a SystemVerilog compiler
package pmic_pkg;
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_UP = 2'b01,
        ST_ON = 2'b10,
        ST_DOWN = 2'b11
    } pwr_state_t;

    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_ALT_BUCK = 3'b001,
        HS_ALT_LDO = 3'b010,
        HS_LOW = 3'b011,
        HS_RESTART = 3'b100,
        HS_SOFTWARE_SWITCH_OFF = 3'b101
    } host_state_t;

    typedef logic [3:0] buck_vec_t;
    typedef logic [5:0] ldo_vec_t;
endpackage : pmic_pkg

// ---- logic/pmic_link_if.sv ----
// wires between the processor end and the power controller end
// the shared reset line is open drain, resolved here from both enables
`timescale 1ns/10ps
interface pmic_link_if;
    logic low_power_request_line;
    logic wake_in;
    logic host_rst_oe_n;
    logic dev_rst_oe_n;
    logic system_reset_n;
    logic wr_valid;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;

    // either party pulling low wins
    assign system_reset_n = host_rst_oe_n & dev_rst_oe_n;

    modport device (
        input low_power_request_line,
        input wake_in,
        output dev_rst_oe_n,
        input system_reset_n,
        input wr_valid,
        input wr_addr,
        input wr_data
    );

    modport host (
        output low_power_request_line,
        output wake_in,
        output host_rst_oe_n,
        input system_reset_n,
        output wr_valid,
        output wr_addr,
        output wr_data
    );
endinterface : pmic_link_if

// ---- logic/pin_sync.sv ----
// three-stage synchroniser with agreement filter and edge pulses
// assumes inputs arrive from outside the clk domain
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // raw pin and filtered view
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q, prev_q;
    logic [WIDTH-1:0] lvl_d;

    // a change counts only once stages two and three agree
    always_comb
    begin
        lvl_d = lvl_q;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (s2_q[i] == s3_q[i])
                lvl_d[i] = s3_q[i];
        end
    end

    // first stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
            lvl_q <= INIT;
            prev_q <= INIT;
        end
        else
        begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
            prev_q <= lvl_q;
        end
    end

    assign level = lvl_q;
    assign rise = lvl_q & ~prev_q;
    assign fall = ~lvl_q & prev_q;
endmodule : pin_sync

// ---- logic/pmic_power_state_controller.sv ----
// power-state controller of the PMIC: off, power-up, on, power-down
// assumes clk at 125 MHz, srst as power-on reset, analog flags asynchronous
//
// What this block does
// (RULE_01) line high main state, low alternate
// (RULE_02) processor programs alternate settings before lowering line
// (RULE_03) run and stop handled identically
// (RULE_04) power-up enables ranks in order, releases reset
// (RULE_05) power-down asserts reset, disables ranks reversed
// (RULE_06) auto turn-on on supply-good rising
// (RULE_07) button falling edge powers up from off
// (RULE_08) wake rising edge powers up from off
// (RULE_09) software switch-off powers down when on
// (RULE_10) long button press powers down
// (RULE_11) thermal shutdown, restart when cooled
// (RULE_12) enabled over-current powers down
// (RULE_13) enabled watchdog expiry turns off
// (RULE_14) supply-good falling powers down
// (RULE_15) off state keeps all regulators disabled
// (RULE_16) restart enable turns turn-off into power cycle
// (RULE_17) set restart bit before switch-off bit
// (RULE_18) buck and LDO keep-on masks hold regulators
// (RULE_19) buck mask bit two holds main I/O buck
// (RULE_20) clear mask bit cycles main I/O buck
// (RULE_21) processor reset forces uninterruptible power cycle
// (RULE_22) rearm reset detection only after line high
// (RULE_23) ranks separated by three milliseconds
// (RULE_24) triggers ignored outside off or on
`timescale 1ns/10ps
`include "pmic_defines.svh"
module pmic_power_state_controller
    import pmic_pkg::*;
#(
    parameter int unsigned RANK_GAP_CYC = (`RANK_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter logic [31:0] LONG_PRESS_CYC =
        32'(64'd1000000000 * `LONG_PRESS_S / `CLK_PERIOD_NS),
    parameter int unsigned WDG_TICK_CYC = `WDG_TICK_NS / `CLK_PERIOD_NS
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // link to the processor
    pmic_link_if.device link,
    // analog indications
    input wire logic supply_ok_rise,
    input wire logic supply_ok_fall,
    input wire logic thermal_shutdown,
    input wire logic [9:0] over_current,
    input wire logic power_button_n,
    // regulator enables and state
    output buck_vec_t buck_en,
    output ldo_vec_t ldo_en,
    output pwr_state_t state
);
    // synchronised pins: button, wake, reset line, supply rise, fall, thermal
    logic [5:0] pin_lvl, pin_rise, pin_fall;
    logic [9:0] oc_lvl;
    logic sync_lp_line;

    pin_sync #(.WIDTH(6), .INIT(6'h05)) u_sync_pins (
        .clk(clk),
        .srst(srst),
        .pin({thermal_shutdown, supply_ok_fall, supply_ok_rise,
              link.system_reset_n, link.wake_in, power_button_n}),
        .level(pin_lvl),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    pin_sync #(.WIDTH(11), .INIT(11'h400)) u_sync_oc (
        .clk(clk),
        .srst(srst),
        .pin({link.low_power_request_line, over_current}),
        .level({sync_lp_line, oc_lvl}),
        .rise(),
        .fall()
    );

    // registers written by the processor
    logic [7:0] ctrl_q, ctrl_d;
    buck_vec_t buck_mask_q, buck_mask_d, alt_buck_q, alt_buck_d;
    ldo_vec_t ldo_mask_q, ldo_mask_d, alt_ldo_q, alt_ldo_d;
    logic [15:0] wdg_load_q, wdg_load_d;
    logic software_switch_off_cmd;

    function automatic logic wr_hit(input logic v, input logic [7:0] a, input logic [7:0] off);
        wr_hit = v && (a == off);
    endfunction : wr_hit

    // configuration writes; switch-off is a command, not stored
    always_comb
    begin
        ctrl_d = ctrl_q;
        buck_mask_d = buck_mask_q;
        ldo_mask_d = ldo_mask_q;
        alt_buck_d = alt_buck_q;
        alt_ldo_d = alt_ldo_q;
        wdg_load_d = wdg_load_q;
        software_switch_off_cmd = 1'b0;
        if (wr_hit(link.wr_valid, link.wr_addr, `REG_CTRL))
        begin
            ctrl_d = link.wr_data & ~(8'h01 << `CTRL_SOFTWARE_SWITCH_OFF);
            software_switch_off_cmd = link.wr_data[`CTRL_SOFTWARE_SWITCH_OFF];
        end
        if (wr_hit(link.wr_valid, link.wr_addr, `REG_BUCK_MASK))
            buck_mask_d = link.wr_data[3:0]; // RULE_18
        if (wr_hit(link.wr_valid, link.wr_addr, `REG_LDO_MASK))
            ldo_mask_d = link.wr_data[5:0]; // RULE_18
        if (wr_hit(link.wr_valid, link.wr_addr, `REG_ALT_BUCK))
            alt_buck_d = link.wr_data[3:0];
        if (wr_hit(link.wr_valid, link.wr_addr, `REG_ALT_LDO))
            alt_ldo_d = link.wr_data[5:0];
        if (wr_hit(link.wr_valid, link.wr_addr, `REG_WDG_LOAD))
            wdg_load_d = {link.wr_data, 8'h00};
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_q <= `CTRL_RESET;
            buck_mask_q <= 4'h0;
            ldo_mask_q <= 6'h00;
            alt_buck_q <= 4'h0;
            alt_ldo_q <= 6'h00;
            wdg_load_q <= `WDG_LOAD_RESET;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            buck_mask_q <= buck_mask_d;
            ldo_mask_q <= ldo_mask_d;
            alt_buck_q <= alt_buck_d;
            alt_ldo_q <= alt_ldo_d;
            wdg_load_q <= wdg_load_d;
        end
    end

    // sequencer state
    pwr_state_t st_q, st_d;
    logic [1:0] rank_q, rank_d;
    logic [31:0] tmr_q, tmr_d, press_q, press_d, tick_q, tick_d;
    logic [15:0] wdg_q, wdg_d;
    logic cycle_q, cycle_d, cool_q, cool_d, armed_q, armed_d, rst_oe_n_q, rst_oe_n_d;
    buck_vec_t buck_q, buck_d, seq_buck;
    ldo_vec_t ldo_q, ldo_d, seq_ldo;
    logic supply_ok, turn_on, turn_off, proc_reset, long_press, wdg_expire;

    assign supply_ok = pin_lvl[3] & ~pin_lvl[4];
    // turn-on only counts in off, turn-off only in on
    assign turn_on = (st_q == ST_OFF) && supply_ok && !pin_lvl[5] && ( // RULE_24
        (ctrl_q[`CTRL_AUTO_ON] && pin_rise[3]) || // RULE_06
        pin_fall[0] || // RULE_07
        pin_rise[1] || // RULE_08
        (cool_q && !pin_lvl[5])); // RULE_11
    assign long_press = (press_q >= LONG_PRESS_CYC); // RULE_10
    assign wdg_expire = ctrl_q[`CTRL_WDG_EN] && (wdg_q == 16'h0000); // RULE_13
    assign proc_reset = (st_q == ST_ON) && armed_q && pin_fall[2]; // RULE_21
    assign turn_off = (st_q == ST_ON) && ( // RULE_24
        software_switch_off_cmd || // RULE_09
        long_press ||
        pin_lvl[5] || // RULE_11
        (ctrl_q[`CTRL_OCP_EN] && (|oc_lvl)) || // RULE_12
        wdg_expire ||
        pin_lvl[4]); // RULE_14

    // regulators reached by the current rank
    always_comb
    begin
        seq_buck = 4'h0;
        seq_ldo = 6'h00;
        if (rank_q >= 2'h1)
            seq_buck = seq_buck | `BUCK_RANK1;
        if (rank_q >= 2'h2)
        begin
            seq_buck = seq_buck | `BUCK_RANK2;
            seq_ldo = seq_ldo | `LDO_RANK2;
        end
        if (rank_q >= 2'h3)
        begin
            seq_buck = seq_buck | `BUCK_RANK3;
            seq_ldo = seq_ldo | `LDO_RANK3;
        end
    end

    // main state machine with rank timer
    always_comb
    begin
        st_d = st_q;
        rank_d = rank_q;
        tmr_d = (tmr_q != 32'h0) ? tmr_q - 32'h1 : tmr_q;
        cycle_d = cycle_q;
        cool_d = cool_q;
        armed_d = armed_q;
        rst_oe_n_d = rst_oe_n_q;
        case (st_q)
            ST_OFF:
            begin
                rst_oe_n_d = 1'b0;
                rank_d = 2'h0;
                if (turn_on)
                begin
                    st_d = ST_UP;
                    rank_d = 2'h1; // RULE_04
                    tmr_d = 32'(RANK_GAP_CYC);
                    cool_d = 1'b0;
                end
            end
            ST_UP:
            begin
                if (tmr_q == 32'h0)
                begin
                    if (rank_q != `LAST_RANK)
                    begin
                        rank_d = rank_q + 2'h1; // RULE_04
                        tmr_d = 32'(RANK_GAP_CYC); // RULE_23
                    end
                    else
                    begin
                        st_d = ST_ON;
                        rst_oe_n_d = 1'b1; // RULE_04
                        cycle_d = 1'b0;
                    end
                end
            end
            ST_ON:
            begin
                // rearm only once the shared line is seen high again
                if (!armed_q && pin_lvl[2] && rst_oe_n_q)
                    armed_d = 1'b1; // RULE_22
                if (proc_reset || turn_off)
                begin
                    st_d = ST_DOWN;
                    rst_oe_n_d = 1'b0; // RULE_05
                    tmr_d = 32'(RANK_GAP_CYC);
                    armed_d = 1'b0;
                    cycle_d = proc_reset || ctrl_q[`CTRL_RESTART]; // RULE_16
                    cool_d = pin_lvl[5] && !proc_reset;
                end
            end
            ST_DOWN:
            begin
                // nothing is sampled here, so the cycle cannot be interrupted
                if (tmr_q == 32'h0)
                begin
                    tmr_d = 32'(RANK_GAP_CYC); // RULE_23
                    if (rank_q != 2'h0)
                        rank_d = rank_q - 2'h1; // RULE_05
                    else if (cycle_q)
                    begin
                        st_d = ST_UP; // RULE_16
                        rank_d = 2'h1;
                    end
                    else
                        st_d = ST_OFF;
                end
            end
            default:
                st_d = ST_OFF;
        endcase
    end

    // button hold counter and watchdog countdown
    always_comb
    begin
        press_d = (st_q == ST_ON && !pin_lvl[0] && !long_press) ? press_q + 32'h1 : 32'h0;
        tick_d = (tick_q == 32'(WDG_TICK_CYC - 1)) ? 32'h0 : tick_q + 32'h1;
        wdg_d = wdg_q;
        if (!ctrl_q[`CTRL_WDG_EN] || st_q != ST_ON ||
            wr_hit(link.wr_valid, link.wr_addr, `REG_WDG_LOAD))
            wdg_d = wdg_load_d;
        else if (tick_q == 32'h0 && wdg_q != 16'h0000)
            wdg_d = wdg_q - 16'h1; // RULE_13
    end

    // regulator outputs; alternate set when on and the request line is low
    always_comb
    begin
        buck_d = seq_buck;
        ldo_d = seq_ldo;
        if (st_q == ST_ON && !sync_lp_line)
        begin
            buck_d = alt_buck_q; // RULE_01
            ldo_d = alt_ldo_q;
        end
        else if (st_q == ST_ON)
        begin
            buck_d = seq_buck; // RULE_03
            ldo_d = seq_ldo;
        end
        // keep-on masks; a clear bit 2 lets the main I/O buck drop
        if (cycle_q && st_q != ST_OFF)
        begin
            buck_d = buck_d | buck_mask_q; // RULE_19 RULE_20
            ldo_d = ldo_d | ldo_mask_q; // RULE_18
        end
        if (st_q == ST_OFF)
        begin
            buck_d = 4'h0; // RULE_15
            ldo_d = 6'h00;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_q <= ST_OFF;
            rank_q <= 2'h0;
            tmr_q <= 32'h0;
            press_q <= 32'h0;
            tick_q <= 32'h0;
            wdg_q <= `WDG_LOAD_RESET;
            cycle_q <= 1'b0;
            cool_q <= 1'b0;
            armed_q <= 1'b0;
            rst_oe_n_q <= 1'b0;
            buck_q <= 4'h0;
            ldo_q <= 6'h00;
        end
        else
        begin
            st_q <= st_d;
            rank_q <= rank_d;
            tmr_q <= tmr_d;
            press_q <= press_d;
            tick_q <= tick_d;
            wdg_q <= wdg_d;
            cycle_q <= cycle_d;
            cool_q <= cool_d;
            armed_q <= armed_d;
            rst_oe_n_q <= rst_oe_n_d;
            buck_q <= buck_d;
            ldo_q <= ldo_d;
        end
    end

    assign link.dev_rst_oe_n = rst_oe_n_q;
    assign buck_en = buck_q;
    assign ldo_en = ldo_q;
    assign state = st_q;
endmodule : pmic_power_state_controller

// ---- logic/processor_power_port.sv ----
// processor end: drives the request line, wake, reset and config writes
// assumes the PMIC end samples writes in the cycle wr_valid is high
`timescale 1ns/10ps
`include "pmic_defines.svh"
module processor_power_port
    import pmic_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // user requests
    input wire logic low_power_req,
    input wire buck_vec_t alt_buck,
    input wire ldo_vec_t alt_ldo,
    input wire logic reboot_req,
    input wire logic wake_req,
    input wire logic reset_req,
    // plain configuration write
    input wire logic cfg_valid,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_data,
    // status
    output logic busy,
    output logic reset_seen_n,
    // link
    pmic_link_if.host link
);
    host_state_t hs_q, hs_d;
    logic lp_q, lp_d, wv_q, wv_d, wake_q, rst_q, busy_q;
    logic [7:0] wa_q, wa_d, wd_q, wd_d;
    logic [7:0] ctrl_shadow_q, ctrl_shadow_d;
    logic line_lvl;

    pin_sync #(.WIDTH(1), .INIT(1'b0)) u_sync_rst (
        .clk(clk),
        .srst(srst),
        .pin(link.system_reset_n),
        .level(line_lvl),
        .rise(),
        .fall()
    );

    // sequencing of writes ahead of line changes
    always_comb
    begin
        hs_d = hs_q;
        lp_d = lp_q;
        wv_d = 1'b0;
        wa_d = wa_q;
        wd_d = wd_q;
        ctrl_shadow_d = ctrl_shadow_q;
        case (hs_q)
            HS_IDLE:
            begin
                if (!low_power_req)
                    lp_d = 1'b1; // RULE_01
                if (reboot_req)
                    hs_d = HS_RESTART;
                else if (low_power_req && lp_q)
                    hs_d = HS_ALT_BUCK;
                else if (cfg_valid)
                begin
                    wv_d = 1'b1;
                    wa_d = cfg_addr;
                    wd_d = cfg_data;
                    if (cfg_addr == `REG_CTRL)
                        ctrl_shadow_d = cfg_data & ~(8'h01 << `CTRL_SOFTWARE_SWITCH_OFF);
                end
            end
            HS_ALT_BUCK:
            begin
                wv_d = 1'b1; // RULE_02
                wa_d = `REG_ALT_BUCK;
                wd_d = {4'h0, alt_buck};
                hs_d = HS_ALT_LDO;
            end
            HS_ALT_LDO:
            begin
                wv_d = 1'b1; // RULE_02
                wa_d = `REG_ALT_LDO;
                wd_d = {2'h0, alt_ldo};
                hs_d = HS_LOW;
            end
            HS_LOW:
            begin
                lp_d = 1'b0; // RULE_01
                hs_d = HS_IDLE;
            end
            HS_RESTART:
            begin
                wv_d = 1'b1; // RULE_17
                wa_d = `REG_CTRL;
                wd_d = ctrl_shadow_q | (8'h01 << `CTRL_RESTART);
                ctrl_shadow_d = wd_d;
                hs_d = HS_SOFTWARE_SWITCH_OFF;
            end
            HS_SOFTWARE_SWITCH_OFF:
            begin
                wv_d = 1'b1; // RULE_17
                wa_d = `REG_CTRL;
                wd_d = ctrl_shadow_q | (8'h01 << `CTRL_SOFTWARE_SWITCH_OFF);
                hs_d = HS_IDLE;
            end
            default:
                hs_d = HS_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            hs_q <= HS_IDLE;
            lp_q <= 1'b1;
            wv_q <= 1'b0;
            wa_q <= 8'h00;
            wd_q <= 8'h00;
            ctrl_shadow_q <= `CTRL_RESET;
            wake_q <= 1'b0;
            rst_q <= 1'b1;
            busy_q <= 1'b0;
        end
        else
        begin
            hs_q <= hs_d;
            lp_q <= lp_d;
            wv_q <= wv_d;
            wa_q <= wa_d;
            wd_q <= wd_d;
            ctrl_shadow_q <= ctrl_shadow_d;
            wake_q <= wake_req;
            rst_q <= ~reset_req; // oe low pulls the shared line
            busy_q <= (hs_d != HS_IDLE);
        end
    end

    assign link.low_power_request_line = lp_q;
    assign link.wake_in = wake_q;
    assign link.host_rst_oe_n = rst_q;
    assign link.wr_valid = wv_q;
    assign link.wr_addr = wa_q;
    assign link.wr_data = wd_q;
    assign busy = busy_q;
    assign reset_seen_n = line_lvl;
endmodule : processor_power_port

// ---- testbench/pmic_link_monitor.sv ----
// checker for the shared reset line, regulator enables and power state
// assumes tb hands in the link nets and controller outputs by name
`timescale 1ns/10ps
module pmic_link_monitor
    import pmic_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // link and controller outputs
    input wire logic host_rst_oe_n,
    input wire logic dev_rst_oe_n,
    input wire logic system_reset_n,
    input wire buck_vec_t buck_en,
    input wire ldo_vec_t ldo_en,
    input wire pwr_state_t state
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // state steps into on and out of the two resting points
    sequence s_enter_on;
        (state == ST_UP) ##1 (state == ST_ON);
    endsequence
    sequence s_leave_off;
        (state == ST_OFF) ##1 (state != ST_OFF);
    endsequence
    sequence s_leave_on;
        (state == ST_ON) ##1 (state != ST_ON);
    endsequence
    chk_off_all_dis: assert property (
        state == ST_OFF |-> buck_en == 4'h0 && ldo_en == 6'h00) else $error("enable while off");
    chk_down_rst_low: assert property (
        state == ST_DOWN |-> !system_reset_n) else $error("reset free in power-down");
    chk_up_rst_held: assert property (
        state == ST_UP |-> !dev_rst_oe_n) else $error("reset released early");
    chk_on_rst_free: assert property (
        s_enter_on |-> dev_rst_oe_n) else $error("reset held after power-up");
    chk_up_rank_order: assert property (
        state == ST_UP && buck_en[0] |-> buck_en[3] && buck_en[2]) else $error("rank order up");
    chk_down_rank_order: assert property (
        state == ST_DOWN && !buck_en[3] |-> !buck_en[0]) else $error("rank order down");
    chk_rank_gap_min: assert property (
        $rose(buck_en[3]) && state == ST_UP |-> $past(buck_en[2], 20)) else $error("gap short");
    chk_off_goes_up: assert property (
        s_leave_off |-> state == ST_UP) else $error("bad exit from off");
    chk_on_goes_down: assert property (
        s_leave_on |-> state == ST_DOWN) else $error("bad exit from on");
    chk_host_rst_cycle: assert property (
        $fell(host_rst_oe_n) && state == ST_ON |-> ##[1:12] state == ST_DOWN)
        else $error("host reset ignored");
endmodule : pmic_link_monitor

// ---- testbench/tb.sv ----
// self-checking bench joining the processor end and the controller end
// assumes short counts: rank gap 20, long press 50, watchdog tick 4
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb;
    import pmic_pkg::*;
    logic clk = 1'b0, srst = 1'b1, low_power_req = 1'b0, reboot_req = 1'b0, wake_req = 1'b0;
    logic reset_req = 1'b0, cfg_valid = 1'b0, busy, reset_seen_n, supply_ok_rise = 1'b0;
    logic supply_ok_fall = 1'b0, thermal_shutdown = 1'b0, power_button_n = 1'b1;
    logic [7:0] cfg_addr = 8'h00, cfg_data = 8'h00;
    logic [9:0] over_current = 10'h000;
    buck_vec_t alt_buck = 4'h0, buck_en;
    ldo_vec_t alt_ldo = 6'h00, ldo_en;
    pwr_state_t state;
    int failures = 0, num_checks = 0;
    logic saw_off, saw_io_off;
    pmic_link_if link();
    processor_power_port i_processor_power_port (.clk(clk), .srst(srst),
        .low_power_req(low_power_req), .alt_buck(alt_buck), .alt_ldo(alt_ldo),
        .reboot_req(reboot_req), .wake_req(wake_req), .reset_req(reset_req),
        .cfg_valid(cfg_valid), .cfg_addr(cfg_addr), .cfg_data(cfg_data), .busy(busy),
        .reset_seen_n(reset_seen_n), .link(link));
    pmic_power_state_controller #(.RANK_GAP_CYC(20), .LONG_PRESS_CYC(32'd50), .WDG_TICK_CYC(4))
    i_pmic_power_state_controller (.clk(clk), .srst(srst), .link(link),
        .supply_ok_rise(supply_ok_rise), .supply_ok_fall(supply_ok_fall),
        .thermal_shutdown(thermal_shutdown), .over_current(over_current),
        .power_button_n(power_button_n), .buck_en(buck_en), .ldo_en(ldo_en), .state(state));
    pmic_link_monitor i_pmic_link_monitor (.clk(clk), .srst(srst),
        .host_rst_oe_n(link.host_rst_oe_n), .dev_rst_oe_n(link.dev_rst_oe_n),
        .system_reset_n(link.system_reset_n), .buck_en(buck_en), .ldo_en(ldo_en), .state(state));
    // 125 MHz clock
    always #4 clk = ~clk;
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // bounded wait for a state, also noting any pass through off or main buck drop
    task automatic wait_st(input pwr_state_t s, input int n);
        int k;
        k = 0;
        saw_off = 1'b0;
        saw_io_off = 1'b0;
        while (state !== s && k < n)
        begin
            @(negedge clk);
            saw_off |= (state === ST_OFF);
            saw_io_off |= (buck_en[2] === 1'b0);
            k++;
        end
        `CHK(state, s)
    endtask : wait_st
    // one-byte configuration write; caller keeps the host idle
    task automatic cfg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        cfg_valid = 1'b1;
        cfg_addr = a;
        cfg_data = d;
        @(negedge clk);
        cfg_valid = 1'b0;
    endtask : cfg
    task automatic wake_on();
        wake_req = 1'b1;
        wait_st(ST_UP, 20);
        cfg(8'h00, 8'h11); // software_switch_off while rising must be ignored
        wait_st(ST_ON, 200);
        cyc(20);
        `CHK(state, ST_ON)
        wake_req = 1'b0;
    endtask : wake_on
    task automatic t_auto_on_alt();
        supply_ok_rise = 1'b1;
        wait_st(ST_UP, 20);
        wait_st(ST_ON, 200);
        `CHK(buck_en, 4'hD)
        `CHK(ldo_en, 6'h18)
        `CHK(link.system_reset_n, 1'b1)
        alt_buck = 4'h4;
        alt_ldo = 6'h10;
        low_power_req = 1'b1;
        cyc(30);
        `CHK(link.low_power_request_line, 1'b0)
        `CHK({buck_en, ldo_en}, {4'h4, 6'h10})
        low_power_req = 1'b0;
        cyc(30);
        `CHK({buck_en, state}, {4'hD, ST_ON})
    endtask : t_auto_on_alt
    task automatic t_software_switch_off_button();
        cfg(8'h00, 8'h11);
        wait_st(ST_DOWN, 20);
        `CHK(link.system_reset_n, 1'b0)
        wait_st(ST_OFF, 200);
        power_button_n = 1'b0;
        wait_st(ST_UP, 20);
        wait_st(ST_ON, 200);
        wait_st(ST_DOWN, 100);
        power_button_n = 1'b1;
        wait_st(ST_OFF, 200);
    endtask : t_software_switch_off_button
    task automatic t_power_cycles();
        wake_on();
        cfg(8'h01, 8'h04);
        reboot_req = 1'b1;
        cyc(1);
        `CHK(busy, 1'b1)
        reboot_req = 1'b0;
        wait_st(ST_DOWN, 20);
        wait_st(ST_UP, 200);
        `CHK(saw_off, 1'b0)
        `CHK(saw_io_off, 1'b0)
        wait_st(ST_ON, 200);
        cfg(8'h01, 8'h00);
        cfg(8'h00, 8'h10);
        reset_req = 1'b1;
        wait_st(ST_DOWN, 20);
        `CHK(reset_seen_n, 1'b0)
        reset_req = 1'b0;
        wait_st(ST_UP, 200);
        `CHK(saw_io_off, 1'b1)
        wait_st(ST_ON, 200);
        cyc(40);
        `CHK(state, ST_ON)
        `CHK({busy, reset_seen_n}, 2'b01)
    endtask : t_power_cycles
    task automatic t_faults();
        cfg(8'h00, 8'h14);
        over_current = 10'h001;
        wait_st(ST_DOWN, 20);
        wait_st(ST_OFF, 200);
        over_current = 10'h000;
        wake_on();
        thermal_shutdown = 1'b1;
        wait_st(ST_DOWN, 20);
        wait_st(ST_OFF, 200);
        cyc(10);
        thermal_shutdown = 1'b0;
        wait_st(ST_ON, 220);
        cfg(8'h05, 8'h01);
        cfg(8'h00, 8'h18);
        cyc(900);
        `CHK(state, ST_ON)
        wait_st(ST_OFF, 400);
        wake_on();
        supply_ok_fall = 1'b1;
        wait_st(ST_DOWN, 20);
        wait_st(ST_OFF, 200);
    endtask : t_faults
    task automatic final_report();
        if (failures == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report
    // main sequence: reset held for 8 cycles
    initial
    begin
        cyc(8);
        srst = 1'b0;
        cyc(4);
        t_auto_on_alt();
        t_software_switch_off_button();
        t_power_cycles();
        t_faults();
        final_report();
    end
    // hang guard well beyond the expected few thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        final_report();
    end
endmodule : tb
